// ---- include/dcs_pkg.sv ----
`default_nettype none
package dcs_pkg;

  // --------------------------------------------------------------
  // Command word layout
  // --------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int BIT_IGNORE = 15;
  localparam int BIT_BUF = 14;
  localparam int BIT_GAIN_N = 13;
  localparam int BIT_ACTIVE = 12;
  localparam int DATA_MSB = 11;
  localparam int DATA_W = 12;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] BIT_COUNT = 5'h10;
  localparam logic [CNT_W-1:0] BIT_LAST = 5'h0F;

  // --------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------
  localparam logic RST_BUF = 1'b0;
  localparam logic RST_GAIN_N = 1'b0;
  localparam logic RST_ACTIVE = 1'b0;
  localparam logic RST_RX_EN = 1'b1;

  // --------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int SETTLE_NS = 10000;
  // Longest time: round down, never below one cycle
  localparam int SETTLE_CYC_I = (SETTLE_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                (SETTLE_NS / CLK_PERIOD_NS);
  localparam int SETTLE_W = 10;
  localparam logic [SETTLE_W-1:0] SETTLE_LAST =
    SETTLE_W'(SETTLE_CYC_I - 1);

  // --------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STAGED = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_ACTIVE = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h0C;
  localparam int CTRL_RX_EN = 0;
  localparam int CTRL_SOFT_LATCH = 1;
  localparam int STAT_VALID = 16;
  localparam int STAT_PEND = 17;
  localparam int STAT_SETTLE = 18;
  localparam int CNT_HALF = 16;

  // --------------------------------------------------------------
  // Bus encodings
  // --------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [2:0] {
    ST_SHUT = 3'h1,
    ST_SETTLE = 3'h2,
    ST_LIVE = 3'h4
  } dcs_state_e;

  // Readback image of a configuration set
  function automatic logic [31:0] pack_cfg(input logic buf_b,
                                           input logic gain_n,
                                           input logic act,
                                           input logic [DATA_W-1:0] d);
    logic [31:0] w;
    w = '0;
    w[BIT_BUF] = buf_b;
    w[BIT_GAIN_N] = gain_n;
    w[BIT_ACTIVE] = act;
    w[DATA_MSB:0] = d;
    return w;
  endfunction

endpackage
`default_nettype wire

// ---- logic/dcs_serial_rx.sv ----
`default_nettype none
module dcs_serial_rx (
  // Reset
  input wire logic rst_i,
  // Serial link
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  // To system domain
  output logic [dcs_pkg::WORD_W-1:0] word_o,
  output logic done_tgl_o
);

  // --------------------------------------------------------------
  // Frame shifter
  // --------------------------------------------------------------
  // The serial clock stops between frames, so the frame is ended
  // by chip select itself and not by a later edge.
  logic frame_clr;
  logic [dcs_pkg::WORD_W-1:0] shift_r;
  logic [dcs_pkg::CNT_W-1:0] cnt_r;
  logic [dcs_pkg::WORD_W-1:0] word_r;
  logic tgl_r;

  assign frame_clr = rst_i | cs_n_i;

  always_ff @(posedge sck_i or posedge frame_clr) begin
    if (frame_clr) begin
      shift_r <= '0;
      cnt_r <= '0;
    end else if (cnt_r != dcs_pkg::BIT_COUNT) begin
      shift_r <= {shift_r[dcs_pkg::WORD_W-2:0], sdi_i};
      cnt_r <= cnt_r + 5'h01;
    end
  end

  // --------------------------------------------------------------
  // Completed word, held until the next full frame
  // --------------------------------------------------------------
  always_ff @(posedge sck_i or posedge rst_i) begin
    if (rst_i) begin
      word_r <= '0;
      tgl_r <= 1'b0;
    end else if (!cs_n_i && cnt_r == dcs_pkg::BIT_LAST) begin
      word_r <= {shift_r[dcs_pkg::WORD_W-2:0], sdi_i};
      tgl_r <= ~tgl_r;
    end
  end

  assign word_o = word_r;
  assign done_tgl_o = tgl_r;

endmodule
`default_nettype wire

// ---- logic/dcs_top.sv ----
// Operation
// - Code width 8, 10 or 12 by parameter
// - Code is unsigned straight binary
// - Gain bit 1 gives 1x, 0 gives 2x
// - Gain bit resets to 0, 2x
// - Bit selects buffered or unbuffered reference
// - Buffer bit resets to 0, unbuffered
// - Shutdown bit resets to 0, output high-Z
// - High-Z until valid write and strobe low
// - Held in reset; leaves after later write
// - Serial input keeps working during shutdown
// - Shutdown disables driver, switches load in
// - Shutdown until write with bit 1 latched
// - Output valid only after 10 us settle
// - 16-bit word: four config bits, code left
// - Bit 15 set means ignore command
// - At least 16 clocks, early deselect aborts, extra clocks ignored
// - Strobe low copies staged into output register
`default_nettype none
module dcs_top #(
  parameter int CODE_W = 12
) (
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Serial link
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  input wire logic output_latch_strobe_n_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Analog section
  output logic [CODE_W-1:0] input_code_o,
  output logic [CODE_W:0] level_o,
  output logic gain_select_n_o,
  output logic ref_buffered_o,
  output logic active_not_shutdown_o,
  output logic amp_enable_o,
  output logic load_switch_o,
  output logic output_valid_o
);

  // --------------------------------------------------------------
  // Build check
  // --------------------------------------------------------------
  // Other widths would misplace the left-aligned code
  if (CODE_W != 8 && CODE_W != 10 && CODE_W != 12) begin : g_bad_w
    $error("CODE_W must be 8, 10 or 12");
  end

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic logic [dcs_pkg::DATA_W-1:0] align_code(
    input logic [CODE_W-1:0] c);
    logic [dcs_pkg::DATA_W-1:0] r;
    r = '0;
    r[dcs_pkg::DATA_MSB -: CODE_W] = c;
    return r;
  endfunction

  // Level in units of Vref / 2^n
  function automatic logic [CODE_W:0] scale_level(
    input logic [CODE_W-1:0] c,
    input logic gain_n);
    logic [CODE_W:0] r;
    r = gain_n ? {1'b0, c} : {c, 1'b0};
    return r;
  endfunction

  // --------------------------------------------------------------
  // Serial receiver, link clock domain
  // --------------------------------------------------------------
  logic [dcs_pkg::WORD_W-1:0] rx_word;
  logic rx_tgl;

  // Runs regardless of shutdown state
  dcs_serial_rx u_rx (
    .rst_i(rst_i),
    .sck_i(sck_i),
    .cs_n_i(cs_n_i),
    .sdi_i(sdi_i),
    .word_o(rx_word),
    .done_tgl_o(rx_tgl)
  );

  // --------------------------------------------------------------
  // Crossings into the system clock
  // --------------------------------------------------------------
  logic tgl_s1_r;
  logic tgl_s2_r;
  logic tgl_d_r;
  logic cs_s1_r;
  logic cs_s2_r;
  logic cs_d1_r;
  logic cs_d2_r;
  logic lat_s1_r;
  logic lat_s2_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_d_r <= 1'b0;
    end else begin
      tgl_s1_r <= rx_tgl;
      tgl_s2_r <= tgl_s1_r;
      tgl_d_r <= tgl_s2_r;
    end
  end

  // Deselect is seen one cycle after the word toggle would be,
  // so a late toggle cannot be mistaken for an aborted frame.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_d1_r <= 1'b1;
      cs_d2_r <= 1'b1;
    end else begin
      cs_s1_r <= cs_n_i;
      cs_s2_r <= cs_s1_r;
      cs_d1_r <= cs_s2_r;
      cs_d2_r <= cs_d1_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lat_s1_r <= 1'b1;
      lat_s2_r <= 1'b1;
    end else begin
      lat_s1_r <= output_latch_strobe_n_i;
      lat_s2_r <= lat_s1_r;
    end
  end

  logic word_seen;
  logic cs_rise;
  logic cs_fall;
  logic strobe_low;

  assign word_seen = tgl_s2_r ^ tgl_d_r;
  assign cs_rise = cs_d1_r & ~cs_d2_r;
  assign cs_fall = ~cs_d1_r & cs_d2_r;
  assign strobe_low = ~lat_s2_r;

  // --------------------------------------------------------------
  // Bus slave registers
  // --------------------------------------------------------------
  logic rx_en_r;
  logic soft_latch_r;
  logic wr_pend_r;
  logic [dcs_pkg::ADDR_W-1:0] wr_addr_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  logic hresp_r;
  logic addr_phase;

  assign addr_phase = hsel_i & hready_i &
                      (htrans_i == dcs_pkg::HTRANS_NONSEQ);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
    end else begin
      wr_pend_r <= addr_phase & hwrite_i &
                   (hsize_i == dcs_pkg::HSIZE_WORD);
      wr_addr_r <= haddr_i[dcs_pkg::ADDR_W-1:0];
    end
  end

  // Soft latch is a one-cycle pulse and reads back as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_en_r <= dcs_pkg::RST_RX_EN;
      soft_latch_r <= 1'b0;
    end else begin
      soft_latch_r <= 1'b0;
      if (wr_pend_r && wr_addr_r == dcs_pkg::OFF_CTRL) begin
        rx_en_r <= hwdata_i[dcs_pkg::CTRL_RX_EN];
        soft_latch_r <= hwdata_i[dcs_pkg::CTRL_SOFT_LATCH];
      end
    end
  end

  // --------------------------------------------------------------
  // Staged input register
  // --------------------------------------------------------------
  logic [dcs_pkg::WORD_W-1:0] cap_word_r;
  logic pend_r;
  logic commit;
  logic refuse;
  logic [CODE_W-1:0] stg_code_r;
  logic stg_gain_n_r;
  logic stg_buf_r;
  logic stg_act_r;

  // Set wins over clear for the pending flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_word_r <= '0;
      pend_r <= 1'b0;
    end else if (word_seen) begin
      cap_word_r <= rx_word;
      pend_r <= 1'b1;
    end else if (cs_rise || cs_fall) begin
      pend_r <= 1'b0;
    end
  end

  assign commit = cs_rise & pend_r & rx_en_r &
                  ~cap_word_r[dcs_pkg::BIT_IGNORE];
  assign refuse = cs_rise & ~commit;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stg_code_r <= '0;
      stg_gain_n_r <= dcs_pkg::RST_GAIN_N;
      stg_buf_r <= dcs_pkg::RST_BUF;
      stg_act_r <= dcs_pkg::RST_ACTIVE;
    end else if (commit) begin
      stg_code_r <= cap_word_r[dcs_pkg::DATA_MSB -: CODE_W];
      stg_gain_n_r <= cap_word_r[dcs_pkg::BIT_GAIN_N];
      stg_buf_r <= cap_word_r[dcs_pkg::BIT_BUF];
      stg_act_r <= cap_word_r[dcs_pkg::BIT_ACTIVE];
    end
  end

  // --------------------------------------------------------------
  // Output register
  // --------------------------------------------------------------
  // Strobe is level-sensitive: held low, the output follows
  // each new commit.
  logic out_load;
  logic [CODE_W-1:0] out_code_r;
  logic [CODE_W:0] level_r;
  logic out_gain_n_r;
  logic out_buf_r;
  logic out_act_r;

  assign out_load = strobe_low | soft_latch_r;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_code_r <= '0;
      level_r <= '0;
      out_gain_n_r <= dcs_pkg::RST_GAIN_N;
      out_buf_r <= dcs_pkg::RST_BUF;
      out_act_r <= dcs_pkg::RST_ACTIVE;
    end else if (out_load) begin
      out_code_r <= stg_code_r;
      level_r <= scale_level(stg_code_r, stg_gain_n_r);
      out_gain_n_r <= stg_gain_n_r;
      out_buf_r <= stg_buf_r;
      out_act_r <= stg_act_r;
    end
  end

  // --------------------------------------------------------------
  // Output stage sequencing
  // --------------------------------------------------------------
  dcs_pkg::dcs_state_e state_r;
  logic [dcs_pkg::SETTLE_W-1:0] settle_cnt_r;
  logic amp_en_r;
  logic load_sw_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= dcs_pkg::ST_SHUT;
      settle_cnt_r <= '0;
    end else begin
      case (state_r)
        dcs_pkg::ST_SHUT: begin
          settle_cnt_r <= '0;
          if (out_act_r) begin
            state_r <= dcs_pkg::ST_SETTLE;
          end
        end
        dcs_pkg::ST_SETTLE: begin
          settle_cnt_r <= settle_cnt_r + 10'h001;
          if (!out_act_r) begin
            state_r <= dcs_pkg::ST_SHUT;
          end else if (settle_cnt_r == dcs_pkg::SETTLE_LAST) begin
            state_r <= dcs_pkg::ST_LIVE;
          end
        end
        dcs_pkg::ST_LIVE: begin
          settle_cnt_r <= '0;
          if (!out_act_r) begin
            state_r <= dcs_pkg::ST_SHUT;
          end
        end
        default: begin
          state_r <= dcs_pkg::ST_SHUT;
          settle_cnt_r <= '0;
        end
      endcase
    end
  end

  // Amplifier powers from settling on; load leaves at the same time
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      amp_en_r <= 1'b0;
      load_sw_r <= 1'b1;
    end else begin
      amp_en_r <= out_act_r;
      load_sw_r <= ~out_act_r;
    end
  end

  // --------------------------------------------------------------
  // Frame statistics
  // --------------------------------------------------------------
  logic [dcs_pkg::CNT_HALF-1:0] acc_cnt_r;
  logic [dcs_pkg::CNT_HALF-1:0] ref_cnt_r;

  // Counters wrap silently; software takes differences
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_cnt_r <= '0;
      ref_cnt_r <= '0;
    end else begin
      if (commit) begin
        acc_cnt_r <= acc_cnt_r + 16'h0001;
      end
      if (refuse) begin
        ref_cnt_r <= ref_cnt_r + 16'h0001;
      end
    end
  end

  // --------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------
  logic [31:0] rd_mux;
  logic ctrl_en_view;

  // Forward a write still in flight so back-to-back reads agree
  assign ctrl_en_view = (wr_pend_r && wr_addr_r == dcs_pkg::OFF_CTRL) ?
                        hwdata_i[dcs_pkg::CTRL_RX_EN] : rx_en_r;

  always_comb begin
    rd_mux = '0;
    case (haddr_i[dcs_pkg::ADDR_W-1:0])
      dcs_pkg::OFF_CTRL: begin
        rd_mux[dcs_pkg::CTRL_RX_EN] = ctrl_en_view;
      end
      dcs_pkg::OFF_STAGED: begin
        rd_mux = dcs_pkg::pack_cfg(stg_buf_r, stg_gain_n_r, stg_act_r,
                                   align_code(stg_code_r));
        rd_mux[dcs_pkg::STAT_PEND] = pend_r;
      end
      dcs_pkg::OFF_ACTIVE: begin
        rd_mux = dcs_pkg::pack_cfg(out_buf_r, out_gain_n_r, out_act_r,
                                   align_code(out_code_r));
        rd_mux[dcs_pkg::STAT_VALID] = state_r[2];
        rd_mux[dcs_pkg::STAT_SETTLE] = state_r[1];
      end
      dcs_pkg::OFF_COUNT: begin
        rd_mux = {ref_cnt_r, acc_cnt_r};
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hrdata_r <= '0;
      hreadyout_r <= 1'b1;
      hresp_r <= dcs_pkg::HRESP_OKAY;
    end else begin
      hreadyout_r <= 1'b1;
      hresp_r <= dcs_pkg::HRESP_OKAY;
      if (addr_phase && !hwrite_i) begin
        hrdata_r <= rd_mux;
      end
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  assign hrdata_o = hrdata_r;
  assign hreadyout_o = hreadyout_r;
  assign hresp_o = hresp_r;
  assign input_code_o = out_code_r;
  assign level_o = level_r;
  assign gain_select_n_o = out_gain_n_r;
  assign ref_buffered_o = out_buf_r;
  assign active_not_shutdown_o = out_act_r;
  assign amp_enable_o = amp_en_r;
  assign load_switch_o = load_sw_r;
  assign output_valid_o = state_r[2];

endmodule
`default_nettype wire

// ---- test/dcs_monitor.sv ----
`default_nettype none
module dcs_monitor #(
  parameter int CODE_W = 12
) (
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Causes of an output load
  input wire logic output_latch_strobe_n_i,
  input wire logic hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  // Analog section
  input wire logic [CODE_W-1:0] input_code_o,
  input wire logic [CODE_W:0] level_o,
  input wire logic gain_select_n_o,
  input wire logic ref_buffered_o,
  input wire logic active_not_shutdown_o,
  input wire logic amp_enable_o,
  input wire logic load_switch_o,
  input wire logic output_valid_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  logic [9:0] on_cnt_r;
  logic [3:0] quiet_r;
  logic [CODE_W:0] exp_level;
  logic [CODE_W+2:0] outs;

  assign exp_level = gain_select_n_o ? {1'b0, input_code_o} :
                     {input_code_o, 1'b0};
  assign outs = {input_code_o, gain_select_n_o, ref_buffered_o,
                 active_not_shutdown_o};

  // Saturates so a long active spell never wraps
  always_ff @(posedge clk_i) begin
    if (rst_i || !active_not_shutdown_o) begin
      on_cnt_r <= 10'h000;
    end else if (on_cnt_r != 10'h3FF) begin
      on_cnt_r <= on_cnt_r + 10'h001;
    end
  end

  // Any bus write may be a soft latch, so it counts as a cause
  always_ff @(posedge clk_i) begin
    if (rst_i || !output_latch_strobe_n_i ||
        (hsel_i && hwrite_i && htrans_i[1])) begin
      quiet_r <= 4'h0;
    end else if (quiet_r != 4'hF) begin
      quiet_r <= quiet_r + 4'h1;
    end
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_level;
    @(posedge clk_i) disable iff (rst_i)
    quiet_r >= 4'h6 |-> level_o == exp_level;
  endproperty
  a_level: assert property (p_level)
    else $error("level does not follow code and gain");

  property p_hold;
    @(posedge clk_i) disable iff (rst_i)
    quiet_r >= 4'h6 |-> $stable(outs);
  endproperty
  a_hold: assert property (p_hold)
    else $error("output register moved without a latch");

  property p_amp_on;
    @(posedge clk_i) disable iff (rst_i)
    $rose(active_not_shutdown_o) |=> amp_enable_o && !load_switch_o;
  endproperty
  a_amp_on: assert property (p_amp_on)
    else $error("driver not enabled after activation");

  property p_amp_off;
    @(posedge clk_i) disable iff (rst_i)
    !active_not_shutdown_o |=> !amp_enable_o && load_switch_o;
  endproperty
  a_amp_off: assert property (p_amp_off)
    else $error("load not switched in during shutdown");

  property p_off_invalid;
    @(posedge clk_i) disable iff (rst_i)
    !active_not_shutdown_o |=> !output_valid_o;
  endproperty
  a_off_invalid: assert property (p_off_invalid)
    else $error("output valid during shutdown");

  property p_valid_min;
    @(posedge clk_i) disable iff (rst_i)
    output_valid_o |-> on_cnt_r >= 10'h1F4;
  endproperty
  a_valid_min: assert property (p_valid_min)
    else $error("output valid before settle time");

  property p_valid_by;
    @(posedge clk_i) disable iff (rst_i)
    on_cnt_r == 10'h1FE |-> output_valid_o;
  endproperty
  a_valid_by: assert property (p_valid_by)
    else $error("output not valid after settle time");

  property p_valid_past;
    @(posedge clk_i) disable iff (rst_i)
    output_valid_o |-> $past(active_not_shutdown_o);
  endproperty
  a_valid_past: assert property (p_valid_past)
    else $error("output valid without active mode");
endmodule

bind dcs_top dcs_monitor #(.CODE_W(CODE_W)) u_mon (
  .clk_i(clk_i), .rst_i(rst_i),
  .output_latch_strobe_n_i(output_latch_strobe_n_i),
  .hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
  .input_code_o(input_code_o), .level_o(level_o),
  .gain_select_n_o(gain_select_n_o), .ref_buffered_o(ref_buffered_o),
  .active_not_shutdown_o(active_not_shutdown_o),
  .amp_enable_o(amp_enable_o), .load_switch_o(load_switch_o),
  .output_valid_o(output_valid_o)
);
`default_nettype wire

// ---- test/dcs_host_model.sv ----
`default_nettype none
module dcs_host_model (
  // Serial link
  output logic sck_o,
  output logic cs_n_o,
  output logic sdi_o,
  // Output latch
  output logic strobe_n_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
    strobe_n_o = 1'b1;
  end

  // Released data line toggles so a stale bit never looks valid
  always #24 begin
    if (cs_n_o) begin
      sdi_o = ~sdi_o;
    end
  end

  // ------------------------------------------------------------
  // Host transfers
  // ------------------------------------------------------------
  // Fewer than 16 clocks aborts; extra clocks carry junk
  task automatic send(input logic [15:0] w, input int n);
    cs_n_o = 1'b0;
    #70;
    for (int i = 0; i < n; i++) begin
      sdi_o = w[15];
      w = {w[14:0], ~w[15]};
      #24 sck_o = 1'b1;
      #24 sck_o = 1'b0;
    end
    #24 cs_n_o = 1'b1;
    #300;
  endtask

  task automatic latch();
    strobe_n_o = 1'b0;
    #100;
    strobe_n_o = 1'b1;
    #100;
  endtask
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
`default_nettype none
`define CHK(g, e) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, (g), (e)); \
  end \
end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int CW = 10;

  logic clk_i, rst_i, sck, cs_n, sdi, strobe_n, hsel_i, hwrite_i;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
  logic [1:0] htrans_i;
  logic [2:0] hsize_i;
  logic hreadyout_o, hresp_o, gain_select_n_o, ref_buffered_o;
  logic active_not_shutdown_o, amp_enable_o, load_switch_o;
  logic output_valid_o;
  logic [CW-1:0] input_code_o;
  logic [CW:0] level_o;
  int n_errors = 0;
  int total_checks = 0;
  int n_acc = 0;
  int n_ref = 0;

  dcs_host_model u_host (.sck_o(sck), .cs_n_o(cs_n), .sdi_o(sdi),
    .strobe_n_o(strobe_n));

  dcs_top #(.CODE_W(CW)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .sck_i(sck), .cs_n_i(cs_n), .sdi_i(sdi),
    .output_latch_strobe_n_i(strobe_n), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .input_code_o(input_code_o), .level_o(level_o),
    .gain_select_n_o(gain_select_n_o), .ref_buffered_o(ref_buffered_o),
    .active_not_shutdown_o(active_not_shutdown_o),
    .amp_enable_o(amp_enable_o), .load_switch_o(load_switch_o),
    .output_valid_o(output_valid_o));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    hsel_i <= 1'b1;
    hwrite_i <= wr;
    haddr_i <= {24'h0, a};
    htrans_i <= dcs_pkg::HTRANS_NONSEQ;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask

  task automatic chk_out(input logic [15:0] w);
    `CHK(input_code_o, w[11 -: CW])
    `CHK(gain_select_n_o, w[13])
    `CHK(ref_buffered_o, w[14])
    `CHK(active_not_shutdown_o, w[12])
    `CHK(load_switch_o, !w[12])
    `CHK(level_o, w[13] ? {1'b0, w[11 -: CW]} : {w[11 -: CW], 1'b0})
  endtask

  // Low code bits unused at this width are masked off
  task automatic chk_stg(input logic [15:0] w);
    bus(1'b0, dcs_pkg::OFF_STAGED, 32'h0);
    `CHK(rd & 32'h7FFC, {16'h0, w} & 32'h7FFC)
  endtask

  task automatic chk_cnt();
    bus(1'b0, dcs_pkg::OFF_COUNT, 32'h0);
    `CHK(rd, {n_ref[15:0], n_acc[15:0]})
    `CHK(hresp_o, dcs_pkg::HRESP_OKAY)
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    chk_out(16'h0000);
    `CHK(output_valid_o, 1'b0)
    chk_cnt();
    bus(1'b0, 8'h10, 32'h0);
    `CHK(rd, 32'h0)
  endtask

  task automatic t_stage();
    u_host.send(16'h7ABC, 16);
    n_acc++;
    chk_out(16'h0000);
    chk_stg(16'h7ABC);
    u_host.latch();
    chk_out(16'h7ABC);
    `CHK(amp_enable_o, 1'b1)
    `CHK(output_valid_o, 1'b0)
    repeat (510) @(posedge clk_i);
    #1;
    `CHK(output_valid_o, 1'b1)
    u_host.send(16'h5FFF, 16);
    n_acc++;
    u_host.latch();
    chk_out(16'h5FFF);
  endtask

  task automatic t_refuse();
    u_host.send(16'h8123, 16);
    u_host.send(16'h7000, 15);
    n_ref += 2;
    u_host.latch();
    chk_out(16'h5FFF);
    u_host.send(16'h5123, 19);
    n_acc++;
    u_host.latch();
    chk_out(16'h5123);
    chk_cnt();
  endtask

  task automatic t_shut();
    u_host.send(16'h2040, 16);
    u_host.latch();
    chk_out(16'h2040);
    `CHK(amp_enable_o, 1'b0)
    `CHK(output_valid_o, 1'b0)
    u_host.send(16'h1800, 16);
    n_acc += 2;
    chk_stg(16'h1800);
    `CHK(active_not_shutdown_o, 1'b0)
    u_host.latch();
    chk_out(16'h1800);
    `CHK(output_valid_o, 1'b0)
  endtask

  // Receive disabled, then soft latch from the bus
  task automatic t_regs();
    bus(1'b1, dcs_pkg::OFF_CTRL, 32'h0);
    u_host.send(16'h7FFF, 16);
    n_ref++;
    bus(1'b1, dcs_pkg::OFF_CTRL, 32'h3);
    repeat (4) @(posedge clk_i);
    #1;
    chk_out(16'h1800);
    u_host.send(16'h7FFF, 16);
    n_acc++;
    bus(1'b1, dcs_pkg::OFF_CTRL, 32'h3);
    repeat (4) @(posedge clk_i);
    #1;
    chk_out(16'h7FFF);
    bus(1'b1, dcs_pkg::OFF_ACTIVE, 32'h0);
    bus(1'b0, dcs_pkg::OFF_ACTIVE, 32'h0);
    `CHK(rd[15:0], 16'h7FFC)
    chk_cnt();
  endtask

  task automatic t_rst();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk_out(16'h0000);
    rst_i <= 1'b0;
    n_acc = 0;
    n_ref = 0;
    chk_cnt();
    u_host.latch();
    chk_out(16'h0000);
    u_host.send(16'h3155, 16);
    u_host.latch();
    chk_out(16'h3155);
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_errors++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    final_report();
  end

  initial begin
    rst_i = 1'b1;
    hsel_i = 1'b0;
    haddr_i = 32'h0;
    htrans_i = 2'h0;
    hwrite_i = 1'b0;
    hsize_i = dcs_pkg::HSIZE_WORD;
    hwdata_i = 32'h0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_stage();
    t_refuse();
    t_shut();
    t_regs();
    t_rst();
    final_report();
  end
endmodule
`default_nettype wire
